/* spr_pkg.sv */
// Operation
// - Frames are four bytes: instruction, input, output, address.
// - Characters are eight data bits, no parity, one stop bit.
// - Bit 7 is 0 in the first byte and 1 in the other three.
// - Bit 6 of the first byte: 0 host to device, 1 device to host.
// - Low six bits of byte one are the instruction code, echoed back.
// - Low seven bits of byte two are the input parameter.
// - Low seven bits of byte three are the output parameter.
// - Byte four: bit 6 override, bit 5 ignored, bits 4..0 address.
// - Override makes every unit execute; only the matching unit replies.
// - Code 2C opens or closes port 1..3 or all, forward or reply path; the code rejects opening all on the reply path.
// - Code 2D reads one port's state on the forward or reply path.
// - A valid command is echoed with the direction bit set.
// - Opening a forward port keeps other forward ports open.
// - Opening a reply port closes any other reply port.
// - Status reply repeats instruction and output; input holds state.
// - Bytes not starting a 2C or 2D command go to the open forward ports.
// - A recognised start collects three bytes; runs if addressed or if the override bit is set.
// - Frame 2C 80 80 81 is answered with 6C 80 80 81.
`default_nettype none
package spr_pkg;
  localparam int unsigned SPR_NPORT = 3;
  localparam int unsigned SPR_AW = 8;
  localparam int unsigned SPR_DW = 32;
  localparam int unsigned SPR_FRAME_BYTES = 4;

  // frame bit positions
  localparam int unsigned SPR_SYNC_BIT = 7;
  localparam int unsigned SPR_DIR_BIT = 6;
  localparam int unsigned SPR_OVR_BIT = 6;
  localparam int unsigned SPR_PATH_BIT = 6;

  localparam logic [5:0] SPR_OP_SET = 6'h2c;
  localparam logic [5:0] SPR_OP_GET = 6'h2d;
  localparam logic [6:0] SPR_ARG_CLOSE = 7'h00;
  localparam logic [6:0] SPR_ARG_OPEN = 7'h01;
  localparam logic [5:0] SPR_PORT_ALL = 6'h00;

  // register byte offsets and field bit positions
  localparam logic [SPR_AW-1:0] SPR_CFG_OFS = 8'h00;
  localparam logic [SPR_AW-1:0] SPR_PORT_OFS = 8'h04;
  localparam logic [SPR_AW-1:0] SPR_STAT_OFS = 8'h08;
  localparam logic [SPR_AW-1:0] SPR_LAST_OFS = 8'h0c;
  localparam int unsigned SPR_REPSEL_LSB = 8;
  localparam int unsigned SPR_DROP_LSB = 16;

  // values after reset
  localparam logic [4:0] SPR_UNIT_RST = 5'h01;
  localparam logic [SPR_NPORT-1:0] SPR_FWD_RST = 3'h7;
  localparam logic [SPR_NPORT-1:0] SPR_REP_RST = 3'h1;

  localparam logic [1:0] SPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPR_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] instr;
    logic [7:0] inp;
    logic [7:0] outp;
    logic [7:0] addr;
  } spr_frame_s;

  typedef enum logic [0:0] {SPR_HUNT, SPR_COLLECT} spr_state_e;
endpackage
`default_nettype wire

/* spr_axil.sv */
`default_nettype none
module spr_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [spr_pkg::SPR_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [spr_pkg::SPR_DW-1:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [spr_pkg::SPR_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [spr_pkg::SPR_DW-1:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic wr_en,
  output logic [spr_pkg::SPR_AW-1:0] wr_addr,
  output logic [spr_pkg::SPR_DW-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [spr_pkg::SPR_AW-1:0] rd_addr,
  input wire logic [spr_pkg::SPR_DW-1:0] rd_data,
  input wire logic rd_err
);
  import spr_pkg::*;

  typedef struct packed {
    logic aw_hold;
    logic w_hold;
    logic [SPR_AW-1:0] awaddr;
    logic [SPR_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [SPR_DW-1:0] rdata;
    logic wr_en;
  } spr_axil_s;

  spr_axil_s r, n;

  always_comb begin
    n = r;
    n.wr_en = 1'b0;
    if (s_axil_awvalid && r.awready) begin
      n.aw_hold = 1'b1;
      n.awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && r.wready) begin
      n.w_hold = 1'b1;
      n.wdata = s_axil_wdata;
      n.wstrb = s_axil_wstrb;
    end
    if (r.bvalid && s_axil_bready) begin
      n.bvalid = 1'b0;
    end
    // wr_err is decoded from the held address, stable while both halves wait
    if (r.aw_hold && r.w_hold) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.wr_en = 1'b1;
      n.bvalid = 1'b1;
      n.bresp = wr_err ? SPR_RESP_SLVERR : SPR_RESP_OKAY;
    end
    if (r.rvalid && s_axil_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axil_arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_err ? '0 : rd_data;
      n.rresp = rd_err ? SPR_RESP_SLVERR : SPR_RESP_OKAY;
    end
    // one write and one read in flight; ready drops until the answer is taken
    n.awready = !n.aw_hold && !n.bvalid && !(r.aw_hold && r.w_hold);
    n.wready = !n.w_hold && !n.bvalid && !(r.aw_hold && r.w_hold);
    n.arready = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign s_axil_awready = r.awready;
  assign s_axil_wready = r.wready;
  assign s_axil_bvalid = r.bvalid;
  assign s_axil_bresp = r.bresp;
  assign s_axil_arready = r.arready;
  assign s_axil_rvalid = r.rvalid;
  assign s_axil_rresp = r.rresp;
  assign s_axil_rdata = r.rdata;
  assign wr_en = r.wr_en;
  assign wr_addr = r.awaddr;
  assign wr_data = r.wdata;
  assign wr_strb = r.wstrb;
  assign rd_addr = s_axil_araddr;
endmodule
`default_nettype wire

/* spr_parser.sv */
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module spr_parser #(
  parameter int unsigned NPORT = spr_pkg::SPR_NPORT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [spr_pkg::SPR_AW-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [spr_pkg::SPR_DW-1:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [spr_pkg::SPR_AW-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [spr_pkg::SPR_DW-1:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic [NPORT-1:0] fwd_valid,
  output logic [7:0] fwd_data,
  input wire logic [NPORT-1:0] ret_valid,
  input wire logic [NPORT-1:0][7:0] ret_data,
  output logic [NPORT-1:0] fwd_mask,
  output logic [NPORT-1:0] rep_sel
);
  import spr_pkg::*;

  typedef struct packed {
    spr_state_e st;
    logic [1:0] cnt;
    spr_frame_s rx_frm;
    logic [NPORT-1:0] fwd_mask;
    logic [NPORT-1:0] rep_sel;
    logic [4:0] unit;
    spr_frame_s last;
    logic [15:0] exec_cnt;
    logic [15:0] drop_cnt;
    spr_frame_s tx_frm;
    logic [2:0] tx_left;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [NPORT-1:0] fwd_valid;
    logic [7:0] fwd_data;
  } spr_core_s;

  localparam logic [NPORT-1:0] ALL_PORTS = {NPORT{1'b1}};

  spr_core_s r, n;

  logic wr_en;
  logic [SPR_AW-1:0] wr_addr;
  logic [SPR_DW-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [SPR_AW-1:0] rd_addr;
  logic [SPR_DW-1:0] rd_data;
  logic rd_err;

  spr_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // register decode; only the configuration word is writable, writes to
  // the read-only words are accepted and ignored
  always_comb begin
    wr_err = !(wr_addr == SPR_CFG_OFS || wr_addr == SPR_PORT_OFS ||
               wr_addr == SPR_STAT_OFS || wr_addr == SPR_LAST_OFS);
    rd_err = 1'b0;
    rd_data = '0;
    if (rd_addr == SPR_CFG_OFS) begin
      rd_data = 32'(r.unit);
    end else if (rd_addr == SPR_PORT_OFS) begin
      rd_data = 32'(r.fwd_mask) | (32'(r.rep_sel) << SPR_REPSEL_LSB);
    end else if (rd_addr == SPR_STAT_OFS) begin
      rd_data = 32'(r.exec_cnt) | (32'(r.drop_cnt) << SPR_DROP_LSB);
    end else if (rd_addr == SPR_LAST_OFS) begin
      rd_data = r.last;
    end else begin
      rd_err = 1'b1;
    end
  end

  logic is_start;
  logic do_exec;
  spr_frame_s frm;
  spr_frame_s rep;
  logic match;
  logic act;
  logic ok;
  logic rx_path;
  logic [5:0] port;
  logic port_ok;
  logic [NPORT-1:0] sel;
  logic [NPORT-1:0] tgt;
  logic opening;
  logic state_bit;
  logic tx_free;
  logic ret_hit;
  logic ret_took;
  logic [7:0] ret_byte;

  always_comb begin
    n = r;
    n.fwd_valid = '0;
    do_exec = 1'b0;
    frm = r.rx_frm;
    rep = r.rx_frm;
    match = 1'b0;
    act = 1'b0;
    ok = 1'b0;
    opening = 1'b0;
    state_bit = 1'b0;
    ret_took = 1'b0;
    ret_byte = '0;
    ret_hit = 1'b0;

    if (wr_en && wr_addr == SPR_CFG_OFS && wr_strb[0]) begin
      n.unit = wr_data[4:0];
    end

    // a start byte has bit 7 clear, direction from host and a known code
    is_start = !rx_data[SPR_SYNC_BIT] && !rx_data[SPR_DIR_BIT] &&
               (rx_data[5:0] == SPR_OP_SET ||
                rx_data[5:0] == SPR_OP_GET);

    if (rx_valid) begin
      if (r.st == SPR_COLLECT && rx_data[SPR_SYNC_BIT]) begin
        unique case (r.cnt)
          2'h0: n.rx_frm.inp = rx_data;
          2'h1: n.rx_frm.outp = rx_data;
          default: begin
            n.rx_frm.addr = rx_data;
            do_exec = 1'b1;
            n.st = SPR_HUNT;
          end
        endcase
        n.cnt = r.cnt + 2'h1;
      end else if (is_start) begin
        // a fresh start also abandons any half-collected frame
        n.rx_frm.instr = rx_data;
        n.cnt = 2'h0;
        n.st = SPR_COLLECT;
      end else begin
        // plain traffic, or a bit-7-clear byte that cut a frame short
        n.st = SPR_HUNT;
        n.fwd_valid = r.fwd_mask;
        n.fwd_data = rx_data;
      end
    end

    frm = {r.rx_frm.instr, r.rx_frm.inp, r.rx_frm.outp, rx_data};
    port = frm.outp[5:0];
    rx_path = frm.outp[SPR_PATH_BIT];
    port_ok = (32'(port) <= NPORT);
    for (int i = 0; i < NPORT; i++) begin
      sel[i] = (port == 6'(i + 1));
    end
    tgt = (port == SPR_PORT_ALL) ? ALL_PORTS : sel;
    state_bit = |((rx_path ? r.rep_sel : r.fwd_mask) & sel);
    rep = frm;
    rep.instr[SPR_DIR_BIT] = 1'b1;

    if (do_exec) begin
      match = (frm.addr[4:0] == r.unit);
      act = match || frm.addr[SPR_OVR_BIT];
      opening = (frm.inp[6:0] == SPR_ARG_OPEN);
      if (frm.instr[5:0] == SPR_OP_SET) begin
        // opening "all" on the reply path would break the single-reply
        // guarantee, so it is treated as unsupported
        ok = (frm.inp[6:0] == SPR_ARG_CLOSE || opening) && port_ok &&
             !(rx_path && opening && port == SPR_PORT_ALL);
        if (act && ok) begin
          if (!rx_path && opening) begin
            n.fwd_mask = r.fwd_mask | tgt;
          end else if (!rx_path) begin
            n.fwd_mask = r.fwd_mask & ~tgt;
          end else if (opening) begin
            n.rep_sel = sel;
          end else begin
            n.rep_sel = r.rep_sel & ~tgt;
          end
        end
      end else begin
        ok = port_ok && port != SPR_PORT_ALL;
        rep.inp = {1'b1, 6'h00, state_bit};
      end
      if (act && ok) begin
        n.exec_cnt = r.exec_cnt + 16'h0001;
        n.last = frm;
      end
      if (match && ok) begin
        // a reply that finds the previous one still going out is lost
        if (r.tx_left == 3'h0) begin
          n.tx_frm = rep;
          n.tx_left = 3'(SPR_FRAME_BYTES);
        end else begin
          n.drop_cnt = r.drop_cnt + 16'h0001;
        end
      end
    end

    // transmit side: own replies first, then the selected return path
    tx_free = !r.tx_valid || tx_ready;
    if (r.tx_valid && tx_ready) begin
      n.tx_valid = 1'b0;
    end
    for (int i = 0; i < NPORT; i++) begin
      if (ret_valid[i] && r.rep_sel[i]) begin
        ret_hit = 1'b1;
        ret_byte = ret_data[i];
      end
    end
    if (tx_free) begin
      if (n.tx_left != 3'h0) begin
        n.tx_valid = 1'b1;
        n.tx_data = n.tx_frm.instr;
        n.tx_frm = spr_frame_s'({n.tx_frm[23:0], 8'h00});
        n.tx_left = n.tx_left - 3'h1;
      end else if (ret_hit) begin
        n.tx_valid = 1'b1;
        n.tx_data = ret_byte;
        ret_took = 1'b1;
      end
    end
    // no buffering on the return path: a byte that cannot go is counted, except in a cycle that already counted a dropped reply
    if (ret_hit && !ret_took && n.drop_cnt == r.drop_cnt) begin
      n.drop_cnt = r.drop_cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= SPR_HUNT;
      r.unit <= SPR_UNIT_RST;
      r.fwd_mask <= NPORT'(SPR_FWD_RST);
      r.rep_sel <= NPORT'(SPR_REP_RST);
    end else begin
      r <= n;
    end
  end

  // character framing lives in the serial front end outside
  assign tx_valid = r.tx_valid;
  assign tx_data = r.tx_data;
  assign fwd_valid = r.fwd_valid;
  assign fwd_data = r.fwd_data;
  assign fwd_mask = r.fwd_mask;
  assign rep_sel = r.rep_sel;
endmodule
`default_nettype wire

/* spr_parser_monitor.sv */
`default_nettype none
module spr_parser_monitor #(
  parameter int unsigned NPORT = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [NPORT-1:0] fwd_valid,
  input wire logic [7:0] fwd_data,
  input wire logic [NPORT-1:0] ret_valid,
  input wire logic [NPORT-1:0] fwd_mask,
  input wire logic [NPORT-1:0] rep_sel
);
  default clocking cb @(posedge aclk);
  endclocking
  // no disable here: this one is about the reset itself
  AST_RST_SETUP: assert property (!aresetn |=> fwd_mask == '1 &&
    rep_sel == NPORT'(1) && !tx_valid)
    else $error("port setup wrong after reset");
  AST_REP_ONEHOT: assert property (disable iff (!aresetn)
    $onehot0(rep_sel))
    else $error("more than one reply port selected");
  AST_TX_HOLD: assert property (disable iff (!aresetn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte not held while stalled");
  AST_FWD_DATA: assert property (disable iff (!aresetn)
    |fwd_valid |-> $past(rx_valid) && fwd_data == $past(rx_data))
    else $error("forwarded byte not the host byte");
  AST_FWD_OPEN: assert property (disable iff (!aresetn)
    |fwd_valid |-> fwd_valid == $past(fwd_mask))
    else $error("forwarded to wrong ports");
  AST_START_KEPT: assert property (disable iff (!aresetn)
    rx_valid && rx_data[7:6] == 2'h0 && rx_data[5:1] == 5'h16
    |=> fwd_valid == '0)
    else $error("command start byte was forwarded");
  AST_SETUP_CAUSE: assert property (disable iff (!aresetn)
    !$stable({fwd_mask, rep_sel}) |-> $past(rx_valid && rx_data[7]))
    else $error("port setup changed without a frame end");
  AST_TX_CAUSE: assert property (disable iff (!aresetn)
    $rose(tx_valid) |-> $past(rx_valid && rx_data[7] ||
    |(ret_valid & rep_sel)))
    else $error("transmit started without cause");
endmodule

bind spr_parser spr_parser_monitor #(.NPORT(NPORT)) i_mon (
  .aclk(aclk), .aresetn(aresetn), .rx_valid(rx_valid),
  .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .fwd_valid(fwd_valid), .fwd_data(fwd_data),
  .ret_valid(ret_valid), .fwd_mask(fwd_mask), .rep_sel(rep_sel)
);
`default_nettype wire

/* spr_host_model.sv */
`default_nettype none
module spr_host_model (
  input wire logic aclk,
  input wire logic slow,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // a slow host stalls the transmitter every other cycle
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  task automatic send(input logic [31:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_data <= f[8*i+:8];
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    // released line shows the inverse so stale data cannot match
    rx_data <= ~rx_data;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spr_pkg::*;
  logic aclk, aresetn, slow;
  logic [7:0] s_axil_awaddr, s_axil_araddr, rx_data, tx_data, fwd_data;
  logic [31:0] s_axil_wdata, s_axil_rdata, rd;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp, rs;
  logic s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic s_axil_rvalid, s_axil_rready, rx_valid, tx_valid, tx_ready;
  logic [2:0] fwd_valid, ret_valid, fwd_mask, rep_sel;
  logic [2:0][7:0] ret_data;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  spr_parser i_dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
    .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
    .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
    .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .rx_valid, .rx_data,
    .tx_valid, .tx_data, .tx_ready, .fwd_valid, .fwd_data, .ret_valid,
    .ret_data, .fwd_mask, .rep_sel);
  spr_host_model i_host (.aclk, .slow, .rx_valid, .rx_data, .tx_valid,
    .tx_data, .tx_ready);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (!s_axil_bvalid);
    rs = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (!s_axil_rvalid);
    rd = s_axil_rdata;
    rs = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask
  task automatic byte1(input logic [7:0] b, input logic [2:0] m);
    i_host.send({24'h0, b}, 1);
    #1;
    chk(fwd_valid, m);
    if (m != 3'h0) chk(fwd_data, b);
  endtask
  // frame, expected reply, reply wanted, forward ports, reply port
  task automatic cmd(input logic [31:0] f, e, input bit r,
    input logic [2:0] m, p);
    int k;
    k = 0;
    i_host.got.delete();
    i_host.send(f, 4);
    #1;
    chk(fwd_mask, m);
    chk(rep_sel, p);
    while (i_host.got.size() < 4 && k < 40) begin
      @(posedge aclk);
      k++;
    end
    if (r)
      chk({i_host.got[0], i_host.got[1], i_host.got[2],
        i_host.got[3]}, e);
    else
      chk(32'(i_host.got.size()), 32'h0);
  endtask
  initial begin
    aresetn = 1'b0;
    slow = 1'b0;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} = 3'h0;
    {s_axil_arvalid, s_axil_rready} = 2'h0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
    s_axil_wstrb = 4'hf;
    ret_valid = 3'h0;
    ret_data = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(SPR_CFG_OFS);
    chk(rd, 32'h1);
    axr(SPR_PORT_OFS);
    chk(rd, 32'h107);
    byte1(8'h41, 3'h7);
    byte1(8'hc5, 3'h7);
    // frames below address unit 1 until the write that sets the unit to 2
    cmd(32'h2c808081, 32'h6c808081, 1, 3'h0, 3'h1);
    byte1(8'h41, 3'h0);
    cmd(32'h2c818281, 32'h6c818281, 1, 3'h2, 3'h1);
    cmd(32'h2c818181, 32'h6c818181, 1, 3'h3, 3'h1);
    cmd(32'h2c81c381, 32'h6c81c381, 1, 3'h3, 3'h4);
    cmd(32'h2c81c181, 32'h6c81c181, 1, 3'h3, 3'h1);
    slow <= 1'b1;
    cmd(32'h2d808281, 32'h6d818281, 1, 3'h3, 3'h1);
    cmd(32'h2d80c281, 32'h6d80c281, 1, 3'h3, 3'h1);
    cmd(32'h2d808381, 32'h6d808381, 1, 3'h3, 3'h1);
    slow <= 1'b0;
    cmd(32'h2c818081, 32'h6c818081, 1, 3'h7, 3'h1);
    cmd(32'h2c858181, 32'h0, 0, 3'h7, 3'h1);
    cmd(32'h2d808081, 32'h0, 0, 3'h7, 3'h1);
    // partial frame cut by a bit-7-clear byte
    i_host.send(32'h2c81, 2);
    byte1(8'h05, 3'h7);
    byte1(8'h81, 3'h7);
    axw(SPR_CFG_OFS, 32'h2);
    chk(rs, SPR_RESP_OKAY);
    axr(SPR_CFG_OFS);
    chk(rd, 32'h2);
    cmd(32'h2c8081c1, 32'h0, 0, 3'h6, 3'h1);
    cmd(32'h2c8181a2, 32'h6c8181a2, 1, 3'h7, 3'h1);
    cmd(32'h2c808283, 32'h0, 0, 3'h7, 3'h1);
    axw(SPR_PORT_OFS, 32'h0);
    chk(rs, SPR_RESP_OKAY);
    axr(SPR_PORT_OFS);
    chk(rd, 32'h107);
    axr(SPR_LAST_OFS);
    chk(rd, 32'h2c8181a2);
    axr(SPR_STAT_OFS);
    chk(rd, 32'h0000000b);
    axr(8'h10);
    chk(rs, SPR_RESP_SLVERR);
    i_host.got.delete();
    @(posedge aclk);
    ret_valid <= 3'h3;
    ret_data <= {8'h00, 8'h33, 8'h5a};
    @(posedge aclk);
    ret_valid <= 3'h0;
    ret_data <= ~ret_data;
    repeat (4) @(posedge aclk);
    chk(32'(i_host.got.size()), 32'h1);
    chk(i_host.got[0], 8'h5a);
    end_sim();
  end
endmodule
`default_nettype wire
